// ---- logic/fllcs_pkg.sv ----
// constants for the clock source selector: register map, fields, resets
// assumes a 32-bit APB slave, one register per aligned word
package fllcs_pkg;
   localparam logic [11:0] FLLCS_OFF_CTRL1 = 12'h000;
   localparam logic [11:0] FLLCS_OFF_CTRL2 = 12'h004;
   localparam logic [11:0] FLLCS_OFF_TRIM = 12'h008;
   localparam logic [11:0] FLLCS_OFF_STAT = 12'h00C;
   localparam logic [11:0] FLLCS_OFF_MODE = 12'h010;
   localparam logic [7:0] FLLCS_CTRL1_RST = 8'h06;
   localparam logic [7:0] FLLCS_CTRL2_RST = 8'h40;
   localparam logic [7:0] FLLCS_TRIM_RST = 8'h80;
   localparam logic [1:0] FLLCS_RANGE_RST = 2'h0;
   localparam logic [1:0] FLLCS_SRC_LOOP = 2'h0;
   localparam logic [1:0] FLLCS_SRC_INT = 2'h1;
   localparam logic [1:0] FLLCS_SRC_EXT = 2'h2;
   localparam logic [1:0] FLLCS_RANGE_BAD = 2'h3;
   localparam logic [2:0] FLLCS_REF_DIVIDER_HI_MAX = 3'h5;
   localparam logic [3:0] FLLCS_HI_RANGE_SHIFT = 4'h5;
   localparam int FLLCS_RESUME_CYC = 2;
   typedef enum logic [2:0] {
      FLLCS_ENG_INT, FLLCS_ENG_EXT, FLLCS_BYP_INT, FLLCS_BYP_INT_LP,
      FLLCS_BYP_EXT, FLLCS_BYP_EXT_LP, FLLCS_STOP
   } fllcs_mode_t;
endpackage

// ---- logic/fllcs_top.sv ----
// clock source selector: mode decode, clock enables, reference gating, APB regs
// assumes loop, internal and external reference ticks arrive as pulses on clk_i
// How it works
// - reset enters loop engaged internal mode, loop selected
// - engaged internal: system from loop, loop on internal ref, debug from loop
// - engaged external: system from loop, loop on external ref, debug from loop
// - bypassed internal: loop runs on ref per reference select, system from internal ref
// - bypassed internal low power: loop off, system from internal ref, no debug
// - bypassed external: loop runs on ref per reference select, system from external ref
// - bypassed external low power: loop off, system from external ref, no debug
// - stop: loop off, no system or debug clock, references per stop enables
// - leaving stop resets loop frequency so lock must be reacquired
// - source field 00 loop, 01 internal, 10 external, 11 as 00
// - selected source divided by 1, 2, 4 or 8
// - external reference divided by 2^code, or 32x that in high range, where code 7 gives 2048 like code 6
// - reference select 1 internal, 0 divided external
// - internal clock enable gates internal reference output
// - internal ref runs in stop only with stop enable and prior enable
// - nine trim bits: eight coarse plus one fine
// - debug clock is loop output halved while the loop runs, in either range
// - three loop ranges and a 32768 Hz max frequency option
// - running low range oscillator keeps running through stop2 when it feeds the system clock or the loop reference
// - bus divider codes 00..11 divide by 1,2,4,8; reset 01
// - low power bit disables loop when bypassed unless debug active
// - range writes ignored while low power set; code 11 ignored
// - reference status follows select after two-flop synchronisation
//
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module fllcs_top
   import fllcs_pkg::*;
(
   // system
   input wire logic clk_i,
   input wire logic reset_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // clock ticks and status from analog side (asynchronous)
   input wire logic loop_tick_i,
   input wire logic int_ref_tick_i,
   input wire logic ext_ref_tick_i,
   input wire logic osc_ready_i,
   input wire logic stop_i,
   input wire logic stop2_i,
   input wire logic debug_active_i,
   // clock enables and controls out
   output logic sys_clk_en_o,
   output logic debug_clk_en_o,
   output logic loop_ref_en_o,
   output logic loop_enable_o,
   output logic loop_freq_reset_o,
   output logic int_ref_clock_out_o,
   output logic ext_ref_clock_out_o,
   output logic ext_osc_enable_o,
   output logic osc_high_gain_o,
   output logic ext_ref_kind_o,
   output logic osc_range_o,
   output logic [1:0] osc_range_status_o,
   output logic max_freq_32k_option_o,
   output logic [8:0] int_ref_trim_o,
   output logic [2:0] mode_o
);
   // control registers
   logic [1:0] source_select_q;
   logic [2:0] ref_divider_q;
   logic int_ref_select_q, int_ref_clock_enable_q, int_ref_stop_enable_q;
   logic [1:0] bus_divider_q;
   logic range_q, osc_high_gain_q, bypass_lowpower_q, ext_ref_kind_q;
   logic ext_ref_clock_enable_q, ext_ref_stop_enable_q;
   logic [7:0] trim_q;
   logic fine_trim_q, max_freq_32k_option_q;
   logic [1:0] osc_range_request_q;

   // two-flop synchronisers for every asynchronous input
   localparam int NSYNC = 7;
   logic [NSYNC-1:0] async_in, sync1_q, sync2_q;
   assign async_in = {debug_active_i, stop2_i, stop_i, osc_ready_i,
                      ext_ref_tick_i, int_ref_tick_i, loop_tick_i};
   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         always_ff @(posedge clk_i) begin
            if (reset_i) begin
               sync1_q[gi] <= 1'b0;
               sync2_q[gi] <= 1'b0;
            end else begin
               sync1_q[gi] <= async_in[gi];
               sync2_q[gi] <= sync1_q[gi];
            end
         end
      end
   endgenerate
   logic loop_s, int_s, ext_s, osc_ready_s, stop_s, stop2_s, dbg_s;
   assign {dbg_s, stop2_s, stop_s, osc_ready_s, ext_s, int_s, loop_s} = sync2_q;

   // rising-edge detect of the synchronised ticks
   logic loop_d1_q, int_d1_q, ext_d1_q, stop_d1_q;
   logic loop_rise, int_rise, ext_rise;
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         loop_d1_q <= 1'b0;
         int_d1_q <= 1'b0;
         ext_d1_q <= 1'b0;
         stop_d1_q <= 1'b0;
      end else begin
         loop_d1_q <= loop_s;
         int_d1_q <= int_s;
         ext_d1_q <= ext_s;
         stop_d1_q <= stop_s;
      end
   end
   assign loop_rise = loop_s & ~loop_d1_q;
   assign int_rise = int_s & ~int_d1_q;
   assign ext_rise = ext_s & ~ext_d1_q;

   // apb decode: writes land on the access edge, reads are fetched in setup
   logic wr_en, rd_en;
   assign wr_en = psel_i & penable_i & pwrite_i;
   assign rd_en = psel_i & ~penable_i & ~pwrite_i;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         {source_select_q, ref_divider_q, int_ref_select_q,
          int_ref_clock_enable_q, int_ref_stop_enable_q} <= FLLCS_CTRL1_RST;
         {bus_divider_q, range_q, osc_high_gain_q, bypass_lowpower_q,
          ext_ref_kind_q, ext_ref_clock_enable_q, ext_ref_stop_enable_q} <= FLLCS_CTRL2_RST;
         trim_q <= FLLCS_TRIM_RST;
         fine_trim_q <= 1'b0;
         max_freq_32k_option_q <= 1'b0;
         osc_range_request_q <= FLLCS_RANGE_RST;
      end else if (wr_en) begin
         case (paddr_i)
            FLLCS_OFF_CTRL1: begin
               {source_select_q, ref_divider_q, int_ref_select_q,
                int_ref_clock_enable_q, int_ref_stop_enable_q} <= pwdata_i[7:0];
            end
            FLLCS_OFF_CTRL2: begin
               {bus_divider_q, range_q, osc_high_gain_q, bypass_lowpower_q,
                ext_ref_kind_q, ext_ref_clock_enable_q, ext_ref_stop_enable_q} <= pwdata_i[7:0];
            end
            FLLCS_OFF_TRIM: begin
               trim_q <= pwdata_i[7:0];
            end
            FLLCS_OFF_STAT: begin
               if (!bypass_lowpower_q && pwdata_i[7:6] != FLLCS_RANGE_BAD) begin
                  osc_range_request_q <= pwdata_i[7:6];
               end
               max_freq_32k_option_q <= pwdata_i[5];
               fine_trim_q <= pwdata_i[0];
            end
            default: begin
            end
         endcase
      end
   end

   // mode decode
   logic [1:0] src_eff;
   logic bypass, loop_on;
   fllcs_mode_t mode;
   assign src_eff = (source_select_q == FLLCS_RANGE_BAD) ? FLLCS_SRC_LOOP : source_select_q;
   assign bypass = (src_eff != FLLCS_SRC_LOOP);
   assign loop_on = ~stop_s & ~(bypass & bypass_lowpower_q & ~dbg_s);
   always_comb begin
      if (stop_s) begin
         mode = FLLCS_STOP;
      end else begin
         case (src_eff)
            FLLCS_SRC_INT: mode = loop_on ? FLLCS_BYP_INT : FLLCS_BYP_INT_LP;
            FLLCS_SRC_EXT: mode = loop_on ? FLLCS_BYP_EXT : FLLCS_BYP_EXT_LP;
            default: mode = int_ref_select_q ? FLLCS_ENG_INT : FLLCS_ENG_EXT;
         endcase
      end
   end

   // external reference divider: 2^code, times 32 in high range, where code 7 divides by 2048 like code 6
   logic [10:0] ref_divider_cnt_q;
   logic [3:0] ref_divider_shift;
   logic [10:0] ref_divider_last;
   assign ref_divider_shift = range_q ? (4'(ref_divider_q) + FLLCS_HI_RANGE_SHIFT) : 4'(ref_divider_q);
   assign ref_divider_last = 11'((12'h001 << ref_divider_shift) - 12'h001);
   logic ext_div_tick;
   assign ext_div_tick = ext_rise & (ref_divider_cnt_q == ref_divider_last);
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ref_divider_cnt_q <= 11'h000;
      end else if (ext_rise) begin
         ref_divider_cnt_q <= (ref_divider_cnt_q >= ref_divider_last) ? 11'h000 : ref_divider_cnt_q + 11'h001;
      end
   end

   // loop reference tick selection
   logic loop_ref_tick;
   assign loop_ref_tick = int_ref_select_q ? int_rise : ext_div_tick;

   // bus divider: switches only on a completed divided period
   logic src_tick;
   logic [2:0] bus_divider_cnt_q;
   logic [1:0] src_act_q, bus_divider_act_q;
   logic [2:0] bus_divider_last;
   always_comb begin
      case (src_act_q)
         FLLCS_SRC_INT: src_tick = int_rise;
         FLLCS_SRC_EXT: src_tick = ext_rise;
         default: src_tick = loop_rise & loop_on;
      endcase
   end
   assign bus_divider_last = 3'((4'h1 << bus_divider_act_q) - 4'h1);
   logic period_end;
   assign period_end = src_tick & (bus_divider_cnt_q == bus_divider_last);
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         bus_divider_cnt_q <= 3'h0;
         src_act_q <= FLLCS_SRC_LOOP;
         bus_divider_act_q <= FLLCS_CTRL2_RST[7:6];
      end else if (src_tick) begin
         bus_divider_cnt_q <= period_end ? 3'h0 : bus_divider_cnt_q + 3'h1;
         if (period_end) begin
            src_act_q <= src_eff;
            bus_divider_act_q <= bus_divider_q;
         end
      end else if (bus_divider_cnt_q == 3'h0 && src_act_q != src_eff) begin
         src_act_q <= src_eff;
      end
   end

   // debug clock: loop halved when loop is running
   logic dbg_half_q;
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         dbg_half_q <= 1'b0;
      end else if (loop_rise & loop_on) begin
         dbg_half_q <= ~dbg_half_q;
      end
   end

   // stop-mode reference keep decisions captured at stop entry
   logic int_keep_q, ext_keep_q;
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         int_keep_q <= 1'b0;
         ext_keep_q <= 1'b0;
      end else if (stop_s & ~stop_d1_q) begin
         int_keep_q <= int_ref_stop_enable_q & int_ref_clock_enable_q;
         ext_keep_q <= (ext_ref_stop_enable_q & ext_ref_clock_enable_q)
                       | (stop2_s & ~range_q & osc_ready_s & ext_ref_kind_q & (src_eff == FLLCS_SRC_EXT
                          | ~int_ref_select_q));
      end
   end

   // range status follows request after synchronisation
   logic [1:0] range_sync1_q, range_stat_q;
   logic ref_sync1_q, ref_stat_q;
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         range_sync1_q <= FLLCS_RANGE_RST;
         range_stat_q <= FLLCS_RANGE_RST;
         ref_sync1_q <= 1'b1;
         ref_stat_q <= 1'b1;
      end else begin
         range_sync1_q <= osc_range_request_q;
         range_stat_q <= range_sync1_q;
         ref_sync1_q <= int_ref_select_q;
         ref_stat_q <= ref_sync1_q;
      end
   end

   // registered outputs
   logic [1:0] resume_cnt_q;
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         sys_clk_en_o <= 1'b0;
         debug_clk_en_o <= 1'b0;
         loop_ref_en_o <= 1'b0;
         loop_enable_o <= 1'b0;
         loop_freq_reset_o <= 1'b1;
         resume_cnt_q <= 2'h0;
         int_ref_clock_out_o <= 1'b0;
         ext_ref_clock_out_o <= 1'b0;
         ext_osc_enable_o <= 1'b0;
         mode_o <= 3'(FLLCS_ENG_INT);
      end else begin
         sys_clk_en_o <= ~stop_s & period_end;
         debug_clk_en_o <= loop_on & loop_rise & dbg_half_q;
         loop_ref_en_o <= loop_on & loop_ref_tick;
         loop_enable_o <= loop_on;
         if (stop_s) begin
            resume_cnt_q <= 2'(FLLCS_RESUME_CYC);
            loop_freq_reset_o <= 1'b1;
         end else if (resume_cnt_q != 2'h0) begin
            resume_cnt_q <= resume_cnt_q - 2'h1;
         end else begin
            loop_freq_reset_o <= 1'b0;
         end
         int_ref_clock_out_o <= int_rise & int_ref_clock_enable_q & (~stop_s | int_keep_q);
         ext_ref_clock_out_o <= ext_rise & ext_ref_clock_enable_q & (~stop_s | ext_keep_q);
         ext_osc_enable_o <= ext_ref_kind_q & (~stop_s | ext_keep_q) &
                             (ext_ref_clock_enable_q | src_eff == FLLCS_SRC_EXT | ~int_ref_select_q);
         mode_o <= 3'(mode);
      end
   end

   assign osc_high_gain_o = osc_high_gain_q;
   assign ext_ref_kind_o = ext_ref_kind_q;
   assign osc_range_o = range_q;
   assign osc_range_status_o = range_stat_q;
   assign max_freq_32k_option_o = max_freq_32k_option_q;
   assign int_ref_trim_o = {trim_q, fine_trim_q};

   // apb read, single access cycle answer
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         prdata_o <= 32'h0000_0000;
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
      end else begin
         pready_o <= psel_i & ~penable_i;
         pslverr_o <= psel_i & ~penable_i & (paddr_i > FLLCS_OFF_MODE);
         prdata_o <= 32'h0000_0000;
         if (rd_en) begin
            case (paddr_i)
               FLLCS_OFF_CTRL1: prdata_o <= {24'h000000, source_select_q, ref_divider_q,
                                             int_ref_select_q, int_ref_clock_enable_q, int_ref_stop_enable_q};
               FLLCS_OFF_CTRL2: prdata_o <= {24'h000000, bus_divider_q, range_q, osc_high_gain_q,
                                             bypass_lowpower_q, ext_ref_kind_q, ext_ref_clock_enable_q,
                                             ext_ref_stop_enable_q};
               FLLCS_OFF_TRIM: prdata_o <= {24'h000000, trim_q};
               FLLCS_OFF_STAT: prdata_o <= {24'h000000, range_stat_q, max_freq_32k_option_q, ref_stat_q,
                                            src_act_q, osc_ready_s, fine_trim_q};
               FLLCS_OFF_MODE: prdata_o <= {29'h00000000, mode_o};
               default: prdata_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   chk_stop_no_clock: assert property (@(posedge clk_i) disable iff (reset_i)
      stop_s |=> !sys_clk_en_o && !debug_clk_en_o && !loop_enable_o)
      else $error("clock enable active during stop");
   chk_lp_loop_off: assert property (@(posedge clk_i) disable iff (reset_i)
      (bypass && bypass_lowpower_q && !dbg_s) |=> !loop_enable_o)
      else $error("loop running in low power bypass");
   chk_ref_status_lag: assert property (@(posedge clk_i) disable iff (reset_i)
      $changed(int_ref_select_q) |-> ##2 (ref_stat_q == $past(int_ref_select_q, 2)))
      else $error("reference status did not follow select");
   chk_range_ignore: assert property (@(posedge clk_i) disable iff (reset_i)
      (wr_en && paddr_i == FLLCS_OFF_STAT && (bypass_lowpower_q || pwdata_i[7:6] == 2'h3))
      |=> $stable(osc_range_request_q))
      else $error("range write not ignored");
   chk_resv_source: assert property (@(posedge clk_i) disable iff (reset_i)
      (source_select_q == 2'h3 && !stop_s) |-> (mode == FLLCS_ENG_INT || mode == FLLCS_ENG_EXT))
      else $error("reserved source not treated as loop");
   chk_int_gate: assert property (@(posedge clk_i) disable iff (reset_i)
      !int_ref_clock_enable_q |=> !int_ref_clock_out_o)
      else $error("internal ref output while disabled");
   chk_stop_refreset: assert property (@(posedge clk_i) disable iff (reset_i)
      $fell(stop_s) |-> loop_freq_reset_o ##1 loop_freq_reset_o)
      else $error("loop frequency not reset across stop exit");
   chk_debug_lp: assert property (@(posedge clk_i) disable iff (reset_i)
      (mode == FLLCS_BYP_INT_LP || mode == FLLCS_BYP_EXT_LP) |=> !debug_clk_en_o)
      else $error("debug clock in low power bypass");
endmodule

// ---- bench/fllcs_tb.sv ----
// self-checking bench for the clock source selector
// assumes fllcs_pkg and fllcs_top are compiled first; ticks are made here on clk_i
`timescale 1ns/1ps
module tb;
   import fllcs_pkg::*;
   logic clk_i, reset_i, psel_i, penable_i, pwrite_i;
   logic [11:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, rd;
   logic pready_o, pslverr_o, err;
   logic loop_tick_i, int_ref_tick_i, ext_ref_tick_i, osc_ready_i, stop_i, stop2_i, debug_active_i;
   logic sys_clk_en_o, debug_clk_en_o, loop_ref_en_o, loop_enable_o, loop_freq_reset_o;
   logic int_ref_clock_out_o, ext_ref_clock_out_o, ext_osc_enable_o, osc_high_gain_o, ext_ref_kind_o;
   logic osc_range_o, max_freq_32k_option_o;
   logic [1:0] osc_range_status_o;
   logic [8:0] int_ref_trim_o;
   logic [2:0] mode_o;
   logic [7:0] tick_q;
   logic [3:0] ext_q;
   int miscompares = 0, n_tests = 0;
   int n_sys, n_dbg, n_lref, n_iro, n_ero;
   // rows: ctrl1, ctrl2, expected mode, expected loop enable
   logic [7:0] r_c1 [9] = '{8'h06, 8'h00, 8'h18, 8'h46, 8'h46, 8'h80, 8'h82, 8'hC6, 8'h08};
   logic [7:0] r_c2 [9] = '{8'h40, 8'h00, 8'h80, 8'hC0, 8'h48, 8'h40, 8'h4A, 8'h00, 8'h20};
   logic [2:0] r_md [9] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h0, 3'h1};
   logic r_le [9] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};

   fllcs_top dut (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .loop_tick_i(loop_tick_i),
      .int_ref_tick_i(int_ref_tick_i), .ext_ref_tick_i(ext_ref_tick_i), .osc_ready_i(osc_ready_i),
      .stop_i(stop_i), .stop2_i(stop2_i), .debug_active_i(debug_active_i),
      .sys_clk_en_o(sys_clk_en_o), .debug_clk_en_o(debug_clk_en_o), .loop_ref_en_o(loop_ref_en_o),
      .loop_enable_o(loop_enable_o), .loop_freq_reset_o(loop_freq_reset_o),
      .int_ref_clock_out_o(int_ref_clock_out_o), .ext_ref_clock_out_o(ext_ref_clock_out_o),
      .ext_osc_enable_o(ext_osc_enable_o), .osc_high_gain_o(osc_high_gain_o),
      .ext_ref_kind_o(ext_ref_kind_o), .osc_range_o(osc_range_o), .osc_range_status_o(osc_range_status_o),
      .max_freq_32k_option_o(max_freq_32k_option_o), .int_ref_trim_o(int_ref_trim_o), .mode_o(mode_o));

   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   // loop period 4, internal 8, external 12 cycles: 96, 48, 32 ticks per 384
   always @(posedge clk_i) begin
      tick_q <= tick_q + 8'h01;
      ext_q <= (ext_q == 4'hB) ? 4'h0 : ext_q + 4'h1;
      loop_tick_i <= tick_q[1];
      int_ref_tick_i <= tick_q[2];
      ext_ref_tick_i <= (ext_q < 4'h6);
   end

   task automatic finish_test();
      $display("tests %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   // pulse counts drift by one at window edges
   task automatic near(input string nm, input int e, input int g);
      n_tests++;
      if (g > e + 1 || g + 1 < e) begin
         miscompares++;
         $display("mismatch %s expected %0d seen %0d", nm, e, g);
      end
   endtask

   // waits for pready at rising edges only; the watchdog bounds a hang
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= wd;
      @(posedge clk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge clk_i);
      end while (pready_o !== 1'b1);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask

   task automatic cycles(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   task automatic count();
      n_sys = 0; n_dbg = 0; n_lref = 0; n_iro = 0; n_ero = 0;
      repeat (384) begin
         @(negedge clk_i);
         n_sys += sys_clk_en_o; n_dbg += debug_clk_en_o; n_lref += loop_ref_en_o;
         n_iro += int_ref_clock_out_o; n_ero += ext_ref_clock_out_o;
      end
   endtask

   task automatic setup(input logic [7:0] c1, input logic [7:0] c2);
      apb(1'b1, FLLCS_OFF_CTRL1, {24'h0, c1});
      apb(1'b1, FLLCS_OFF_CTRL2, {24'h0, c2});
      cycles(160);
   endtask

   task automatic do_reset();
      reset_i <= 1'b1;
      cycles(4);
      reset_i <= 1'b0;
      @(posedge clk_i);
   endtask

   initial begin
      int k, src, srct;
      reset_i = 1'b1; psel_i = 1'b0; penable_i = 1'b0; pwrite_i = 1'b0; paddr_i = 12'h000;
      pwdata_i = 32'h0; loop_tick_i = 1'b0; int_ref_tick_i = 1'b0; ext_ref_tick_i = 1'b0;
      osc_ready_i = 1'b0; stop_i = 1'b0; stop2_i = 1'b0; debug_active_i = 1'b0;
      tick_q = 8'h00; ext_q = 4'h0;
      do_reset();
      chk("mode out", 32'(FLLCS_ENG_INT), 32'(mode_o));
      apb(1'b0, FLLCS_OFF_CTRL1, 32'h0);
      chk("ctrl1 reset", 32'(FLLCS_CTRL1_RST), rd);
      apb(1'b0, FLLCS_OFF_CTRL2, 32'h0);
      chk("ctrl2 reset", 32'(FLLCS_CTRL2_RST), rd);
      apb(1'b0, FLLCS_OFF_TRIM, 32'h0);
      chk("trim reset", 32'(FLLCS_TRIM_RST), rd);
      $display("test reset done");
      for (k = 0; k < 9; k++) begin
         setup(r_c1[k], r_c2[k]);
         chk("mode", 32'(r_md[k]), 32'(mode_o));
         chk("range out", 32'(r_c2[k][5]), 32'(osc_range_o));
         chk("loop enable", 32'(r_le[k]), 32'(loop_enable_o));
         apb(1'b0, FLLCS_OFF_MODE, 32'h0);
         chk("mode readback", 32'(r_md[k]), rd);
         apb(1'b0, FLLCS_OFF_STAT, 32'h0);
         src = r_c1[k][7:6] == 2'h3 ? 0 : int'(r_c1[k][7:6]);
         chk("source status", 32'(src), 32'(rd[3:2]));
         chk("ref status", 32'(r_c1[k][2]), 32'(rd[4]));
         count();
         srct = src == 0 ? 96 : (src == 1 ? 48 : 32);
         near("sys pulses", srct >> r_c2[k][7:6], n_sys);
         near("debug pulses", r_le[k] ? 48 : 0, n_dbg);
         if (r_le[k]) near("loop ref", r_c1[k][2] ? 48 : (r_c2[k][5] ? 0 : 32 >> r_c1[k][5:3]), n_lref);
         near("int out", r_c1[k][1] ? 48 : 0, n_iro);
         near("ext out", r_c2[k][1] ? 32 : 0, n_ero);
         $display("test row %0d done", k);
      end
      // stop with internal kept, external dropped, then the reverse
      setup(8'h07, 8'h42);
      stop_i <= 1'b1;
      cycles(20);
      chk("stop mode", 32'(FLLCS_STOP), 32'(mode_o));
      chk("stop loop", 32'h0, 32'(loop_enable_o));
      chk("stop freq reset", 32'h1, 32'(loop_freq_reset_o));
      count();
      near("stop sys", 0, n_sys);
      near("stop dbg", 0, n_dbg);
      near("stop int kept", 48, n_iro);
      near("stop ext off", 0, n_ero);
      stop_i <= 1'b0;
      @(negedge clk_i);
      chk("exit freq reset", 32'h1, 32'(loop_freq_reset_o));
      cycles(12);
      chk("freq reset released", 32'h0, 32'(loop_freq_reset_o));
      setup(8'h05, 8'h43);
      stop_i <= 1'b1;
      cycles(20);
      count();
      near("stop int off", 0, n_iro);
      near("stop ext kept", 32, n_ero);
      stop_i <= 1'b0;
      $display("test stop done");
      // low range oscillator running in engaged external keeps through stop2
      osc_ready_i <= 1'b1;
      setup(8'h00, 8'h06);
      stop2_i <= 1'b1;
      stop_i <= 1'b1;
      cycles(20);
      chk("stop2 osc kept", 32'h1, 32'(ext_osc_enable_o));
      stop_i <= 1'b0;
      stop2_i <= 1'b0;
      setup(8'h06, 8'h04);
      stop2_i <= 1'b1;
      stop_i <= 1'b1;
      cycles(20);
      chk("stop2 osc off", 32'h0, 32'(ext_osc_enable_o));
      stop_i <= 1'b0;
      stop2_i <= 1'b0;
      cycles(20);
      $display("test stop2 done");
      // status writes: range, option, fine trim, refused range codes
      apb(1'b1, FLLCS_OFF_STAT, 32'h61);
      cycles(8);
      apb(1'b0, FLLCS_OFF_STAT, 32'h0);
      chk("status fields", 32'h61, rd & 32'hE1);
      chk("osc ready", 32'h1, 32'(rd[1]));
      chk("trim out", 32'h101, 32'(int_ref_trim_o));
      chk("range status", 32'h1, 32'(osc_range_status_o));
      chk("max option", 32'h1, 32'(max_freq_32k_option_o));
      apb(1'b1, FLLCS_OFF_STAT, 32'hE1);
      apb(1'b0, FLLCS_OFF_STAT, 32'h0);
      chk("range code 11", 32'h1, 32'(rd[7:6]));
      setup(8'h06, 8'h48);
      apb(1'b1, FLLCS_OFF_STAT, 32'hA1);
      apb(1'b0, FLLCS_OFF_STAT, 32'h0);
      chk("range under lp", 32'h1, 32'(rd[7:6]));
      $display("test status done");
      // low power bypass with debug active keeps the loop
      setup(8'h46, 8'h48);
      debug_active_i <= 1'b1;
      cycles(20);
      chk("debug keeps loop", 32'h1, 32'(loop_enable_o));
      debug_active_i <= 1'b0;
      cycles(20);
      chk("loop off lp", 32'h0, 32'(loop_enable_o));
      apb(1'b1, FLLCS_OFF_CTRL2, 32'h34);
      cycles(1);
      chk("high gain", 32'h1, 32'(osc_high_gain_o));
      chk("range high", 32'h1, 32'(osc_range_o));
      chk("ext kind", 32'h1, 32'(ext_ref_kind_o));
      apb(1'b0, 12'h014, 32'h0);
      chk("unmapped err", 32'h1, 32'(err));
      chk("unmapped data", 32'h0, rd);
      apb(1'b1, FLLCS_OFF_TRIM, 32'h33);
      do_reset();
      chk("mode after reset", 32'(FLLCS_ENG_INT), 32'(mode_o));
      apb(1'b0, FLLCS_OFF_TRIM, 32'h0);
      chk("trim after reset", 32'(FLLCS_TRIM_RST), rd);
      $display("test misc done");
      finish_test();
   end

   initial begin
      repeat (40000) @(posedge clk_i);
      miscompares++;
      $display("mismatch watchdog expected done seen hang");
      finish_test();
   end
endmodule
